// file: pkg/adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ==========================================
// Register offsets
`define ADC_CTL1_ADDR       4'h0
`define ADC_CTL3_ADDR       4'h1
`define ADC_RESULT_ADDR     4'h2
`define ADC_CHAN_ADDR       4'h3
// ==========================================
// Control register one fields
`define CTL1_ON_BIT         15
`define CTL1_TRIG_HI        7
`define CTL1_TRIG_LO        4
`define CTL1_AUTO_BIT       2
`define CTL1_SAMPLE_BIT     1
`define CTL1_DONE_BIT       0
// ==========================================
// Control register three fields
`define CTL3_RC_BIT         15
`define CTL3_COUNT_HI       12
`define CTL3_COUNT_LO       8
`define CTL3_PRE_HI         7
`define CTL3_PRE_LO         0
// ==========================================
// Trigger codes, reset values, timing
`define TRIG_SOFTWARE       4'h0
`define TRIG_CLOCKED        4'h7
`define CTL1_RESET          16'h0001
`define CTL3_RESET          16'h0000
`define CONV_PERIODS        5'h0C
`define CHAN_COUNT          5'h10
`endif

// file: pkg/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONV   = 3'b100
    } seq_state_type;
endpackage
`default_nettype wire

// file: rtl/adc_tad_gen.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Conversion clock tick generator
module adc_tad_gen
(
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       run_i,
    input  wire logic       rc_clock_select_i,
    input  wire logic [7:0] conv_clock_prescale_i,
    input  wire logic       rc_osc_i,
    // Tick
    output logic            tad_tick_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [2:0] rc_sync;
        logic       rc_level;
        logic       tick;
    } tad_state_type;

    tad_state_type r;
    tad_state_type next_r;

    always_comb
    begin
        next_r = r;
        next_r.tick = 1'b0;
        next_r.rc_sync = {r.rc_sync[1:0], rc_osc_i};
        // Level moves only once second and third stages agree
        if (r.rc_sync[2] == r.rc_sync[1])
            next_r.rc_level = r.rc_sync[2];
        if (!run_i)
        begin
            next_r.cnt = 8'h00;
        end
        else if (rc_clock_select_i)
        begin
            // One tick per settled rising edge; slow oscillator only
            next_r.tick = (r.rc_sync[2] == r.rc_sync[1]) & r.rc_sync[2] & ~r.rc_level;
        end
        else if (r.cnt >= conv_clock_prescale_i)
        begin
            next_r.cnt  = 8'h00;
            next_r.tick = 1'b1;
        end
        else
        begin
            next_r.cnt = r.cnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            r <= '0;
        else
            r <= next_r;
    end

    assign tad_tick_o = r.tick;
endmodule // adc_tad_gen
`default_nettype wire

// file: rtl/adc_sar_core.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Twelve-period conversion timer
module adc_sar_core
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // Control
    input  wire logic        start_i,
    input  wire logic        abort_i,
    input  wire logic        tad_tick_i,
    input  wire logic [11:0] analog_code_i,
    // Result
    output logic             busy_o,
    output logic             done_o,
    output logic [11:0]      code_o
);
    `include "adc_seq_map.svh"

    typedef struct packed {
        logic        busy;
        logic [4:0]  periods;
        logic        done;
        logic [11:0] code;
    } sar_state_type;

    sar_state_type r;
    sar_state_type next_r;

    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        if (abort_i)
        begin
            next_r.busy    = 1'b0;
            next_r.periods = 5'h00;
        end
        else if (start_i && !r.busy)
        begin
            next_r.busy    = 1'b1;
            next_r.periods = 5'h00;
        end
        else if (r.busy && tad_tick_i)
        begin
            if (r.periods == `CONV_PERIODS - 5'h01)
            begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                next_r.code = analog_code_i;
            end
            next_r.periods = r.periods + 5'h01;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            r <= '0;
        else
            r <= next_r;
    end

    assign busy_o = r.busy;
    assign done_o = r.done;
    assign code_o = r.code;
endmodule // adc_sar_core
`default_nettype wire

// file: rtl/adc_sample_convert_sequencer.sv
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Sample and convert sequencer
module adc_sample_convert_sequencer
    import adc_seq_pkg::*;
#(
    parameter int CHANNELS = 16
)
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // Register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic [15:0]      reg_rdata_o,
    // Analog side
    input  wire logic        rc_osc_i,
    input  wire logic [11:0] analog_code_i,
    output logic             sampling_o,
    output logic             converting_o,
    output logic [4:0]       channel_o
);
    import adc_seq_pkg::*;
    `include "adc_seq_map.svh"

    typedef struct packed {
        seq_state_type state;
        logic          module_on;
        logic [3:0]    trigger_source_sel;
        logic          auto_sample_en;
        logic          sample_ctl_bit;
        logic          done;
        logic          rc_clock_select;
        logic [4:0]    sample_clock_count;
        logic [7:0]    conv_clock_prescale;
        logic [4:0]    sample_periods;
        logic [4:0]    channel;
        logic [11:0]   result;
        logic [15:0]   rdata;
    } seq_reg_type;

    seq_reg_type r;
    seq_reg_type next_r;

    logic        tad_tick;
    logic        conv_busy;
    logic        conv_done;
    logic [11:0] conv_code;
    logic        conv_start;

    function automatic logic [15:0] ctl1_word(input seq_reg_type s);
        logic [15:0] w;
        w = 16'h0000;
        w[`CTL1_ON_BIT] = s.module_on;
        w[`CTL1_TRIG_HI:`CTL1_TRIG_LO] = s.trigger_source_sel;
        w[`CTL1_AUTO_BIT] = s.auto_sample_en;
        w[`CTL1_SAMPLE_BIT] = s.sample_ctl_bit;
        w[`CTL1_DONE_BIT] = s.done;
        return w;
    endfunction

    function automatic logic [4:0] next_chan(input logic [4:0] c);
        next_chan = (c == 5'(CHANNELS - 1)) ? 5'h00 : c + 5'h01;
    endfunction

    adc_tad_gen u_tad
    (
        .core_clk_i            (core_clk_i),
        .rst_n_i               (rst_n_i),
        .run_i                 (r.module_on),
        .rc_clock_select_i     (r.rc_clock_select),
        .conv_clock_prescale_i (r.conv_clock_prescale),
        .rc_osc_i              (rc_osc_i),
        .tad_tick_o            (tad_tick)
    );

    adc_sar_core u_core
    (
        .core_clk_i    (core_clk_i),
        .rst_n_i       (rst_n_i),
        .start_i       (conv_start),
        .abort_i       (~next_r.module_on),
        .tad_tick_i    (tad_tick),
        .analog_code_i (analog_code_i),
        .busy_o        (conv_busy),
        .done_o        (conv_done),
        .code_o        (conv_code)
    );

    always_comb
    begin
        next_r     = r;
        conv_start = 1'b0;
        next_r.rdata = 16'h0000;

        // ==========================================
        // Register reads
        if (reg_read_i)
        begin
            case (reg_addr_i)
                `ADC_CTL1_ADDR:   next_r.rdata = ctl1_word(r);
                `ADC_CTL3_ADDR:   next_r.rdata = {r.rc_clock_select, 2'b00, r.sample_clock_count,
                                                  r.conv_clock_prescale};
                `ADC_RESULT_ADDR: next_r.rdata = {4'h0, r.result};
                `ADC_CHAN_ADDR:   next_r.rdata = {11'h000, r.channel};
                default:          next_r.rdata = 16'h0000;
            endcase
        end

        // ==========================================
        // Register writes
        if (reg_write_i && reg_addr_i == `ADC_CTL1_ADDR)
        begin
            next_r.module_on      = reg_wdata_i[`CTL1_ON_BIT];
            // software keeps trigger fixed while on
            next_r.trigger_source_sel = reg_wdata_i[`CTL1_TRIG_HI:`CTL1_TRIG_LO];
            next_r.auto_sample_en = reg_wdata_i[`CTL1_AUTO_BIT];
            next_r.sample_ctl_bit = reg_wdata_i[`CTL1_SAMPLE_BIT];
        end
        if (reg_write_i && reg_addr_i == `ADC_CTL3_ADDR)
        begin
            next_r.rc_clock_select     = reg_wdata_i[`CTL3_RC_BIT];
            next_r.sample_clock_count  = reg_wdata_i[`CTL3_COUNT_HI:`CTL3_COUNT_LO];
            next_r.conv_clock_prescale = reg_wdata_i[`CTL3_PRE_HI:`CTL3_PRE_LO];
        end
        if (reg_write_i && reg_addr_i == `ADC_CHAN_ADDR)
            next_r.channel = reg_wdata_i[4:0];

        // ==========================================
        // Sequencer
        case (r.state)
            ST_IDLE:
            begin
                if (next_r.module_on && (next_r.sample_ctl_bit || next_r.auto_sample_en))
                begin
                    // Auto enable starts sampling too; bit reads back set
                    next_r.sample_ctl_bit = 1'b1;
                    next_r.state          = ST_SAMPLE;
                    next_r.sample_periods = 5'h00;
                end
            end
            ST_SAMPLE:
            begin
                if (r.sample_periods != 5'h1F && tad_tick)
                    next_r.sample_periods = r.sample_periods + 5'h01;
                if (r.trigger_source_sel == `TRIG_SOFTWARE && !next_r.sample_ctl_bit)
                    conv_start = 1'b1;
                if (r.trigger_source_sel == `TRIG_CLOCKED && tad_tick
                    && r.sample_periods + 5'h01 >= r.sample_clock_count)
                    conv_start = 1'b1;
                if (conv_start)
                begin
                    next_r.state          = ST_CONV;
                    next_r.sample_ctl_bit = 1'b0;
                    next_r.done           = 1'b0;
                end
            end
            ST_CONV:
            begin
                if (conv_done)
                begin
                    next_r.result = conv_code;
                    next_r.done   = 1'b1;
                    if (next_r.auto_sample_en)
                    begin
                        next_r.channel = next_chan(next_r.channel);
                        next_r.sample_ctl_bit = 1'b1;
                        next_r.sample_periods = 5'h00;
                        next_r.state          = ST_SAMPLE;
                    end
                    else
                    begin
                        // sample 0 and done 1 idle
                        next_r.state = ST_IDLE;
                    end
                end
            end
            default:
                next_r.state = ST_IDLE;
        endcase

        if (!next_r.module_on)
        begin
            next_r.state = ST_IDLE;
            if (r.state == ST_CONV)
                next_r.done = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            r <= '0;
            r.state <= ST_IDLE;
            r.done  <= 1'b1;
        end
        else
            r <= next_r;
    end

    assign reg_rdata_o  = r.rdata;
    assign sampling_o   = (r.state == ST_SAMPLE);
    assign converting_o = conv_busy;
    assign channel_o    = r.channel;
endmodule // adc_sample_convert_sequencer
`default_nettype wire

// file: test/adc_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"
// ==========================================
// Sequencer port checks
module adc_seq_asserts
#(
    parameter int CHANNELS = 16
)
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // Register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    input  wire logic [15:0] reg_rdata_o,
    // Analog side
    input  wire logic        rc_osc_i,
    input  wire logic [11:0] analog_code_i,
    input  wire logic        sampling_o,
    input  wire logic        converting_o,
    input  wire logic [4:0]  channel_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Wrap kept here so a wrong modulus shows up
    logic [4:0] next_chan;
    assign next_chan = (channel_o == 5'(CHANNELS - 1)) ? 5'h00 : channel_o + 5'h01;
    state_excl_a: assert property (!(sampling_o && converting_o))
        else $error("sampling and converting together");
    rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside read slot");
    conv_from_sample_a: assert property ($rose(converting_o) |-> $past(sampling_o))
        else $error("conversion without sampling");
    conv_min_len_a: assert property ($rose(converting_o) |-> converting_o [*8])
        else $error("conversion too short");
    chan_step_a: assert property ($changed(channel_o) |-> $past(reg_write_i) || channel_o == $past(next_chan))
        else $error("channel skipped");
    resample_cause_a: assert property ($rose(sampling_o) && !$past(reg_write_i)
        |-> $past(converting_o) || $past(converting_o, 2))
        else $error("sampling restarted without conversion end");
    off_abort_a: assert property (reg_write_i && reg_addr_i == `ADC_CTL1_ADDR && !reg_wdata_i[`CTL1_ON_BIT]
        |=> !converting_o && !sampling_o)
        else $error("module off did not stop");
    manual_start_a: assert property (reg_write_i && reg_addr_i == `ADC_CTL1_ADDR && reg_wdata_i[15]
        && reg_wdata_i[`CTL1_SAMPLE_BIT] && !converting_o |=> sampling_o)
        else $error("sampling not started");
endmodule // adc_seq_asserts
`default_nettype wire

// file: test/adc_sample_convert_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.svh"
// ==========================================
// Sequencer bench
module adc_sample_convert_sequencer_tb;
    import adc_seq_pkg::*;
    logic        core_clk_i    = 1'b0;
    logic        rst_n_i       = 1'b0;
    logic [3:0]  reg_addr_i    = 4'h0;
    logic [15:0] reg_wdata_i   = 16'h0000;
    logic        reg_write_i   = 1'b0;
    logic        reg_read_i    = 1'b0;
    logic        rc_osc_i      = 1'b0;
    logic        rc_half       = 1'b0;
    logic [11:0] analog_code_i = 12'h000;
    logic [15:0] reg_rdata_o;
    logic        sampling_o;
    logic        converting_o;
    logic [4:0]  channel_o;
    logic [4:0]  ch;
    int          err_total;
    int          compares;
    int          cycles;
    int          n;
    always #12.5 core_clk_i = ~core_clk_i;
    // RC stand-in: four core cycles a period, slow enough to settle
    localparam int RC_PERIOD = 4;
    always @(posedge core_clk_i) {rc_osc_i, rc_half} <= {rc_osc_i, rc_half} + 2'h1;
    adc_sample_convert_sequencer #(.CHANNELS(16)) DUT (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .rc_osc_i(rc_osc_i),
        .analog_code_i(analog_code_i), .sampling_o(sampling_o), .converting_o(converting_o),
        .channel_o(channel_o));
    // ==========================================
    // Tasks
    task end_of_test;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge core_clk_i);
        reg_write_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge core_clk_i);
        reg_read_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    // Counts cycles of a level; bounded so a stuck flag cannot hang
    task span(input bit conv, output int len);
        len = 0;
        #1;
        while ((conv ? converting_o : sampling_o) === 1'b1 && len < 4000)
        begin
            @(posedge core_clk_i);
            #1 len++;
        end
    endtask
    // Sampling resumes a cycle after a conversion ends
    task wait_sampling;
        while (sampling_o !== 1'b1)
        begin
            @(posedge core_clk_i);
            #1;
        end
    endtask
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end
    // ==========================================
    // Scenarios
    initial
    begin
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd(`ADC_CTL1_ADDR, `CTL1_RESET);
        rd(`ADC_CTL3_ADDR, `CTL3_RESET);
        rd(4'hF, 16'h0000);
        for (int p = 0; p < 3; p += 2)
        begin
            wr(`ADC_CTL3_ADDR, 16'(p));
            analog_code_i <= 12'h5A0 + 12'(p);
            wr(`ADC_CTL1_ADDR, 16'h8002);
            #1 chk(16'(sampling_o), 16'h0001);
            repeat (4) @(posedge core_clk_i);
            wr(`ADC_CTL1_ADDR, 16'h8000);
            span(1'b1, n);
            // Divider runs free: prescale 2 leaves a first period one short
            chk(16'(n), 16'(12 * (p + 1) - p / 2));
            rd(`ADC_RESULT_ADDR, {4'h0, 12'h5A0 + 12'(p)});
            rd(`ADC_CTL1_ADDR, 16'h8001);
            repeat (10) @(posedge core_clk_i);
            #1 chk(16'(sampling_o), 16'h0000);
        end
        wr(`ADC_CTL1_ADDR, 16'h8006);
        repeat (4) @(posedge core_clk_i);
        ch = channel_o;
        wr(`ADC_CTL1_ADDR, 16'h8004);
        rd(`ADC_CTL1_ADDR, 16'h8004);
        span(1'b1, n);
        repeat (2) @(posedge core_clk_i);
        #1 chk(16'(sampling_o), 16'h0001);
        rd(`ADC_CTL1_ADDR, 16'h8007);
        chk(16'(channel_o), 16'((ch + 5'h01) % 5'h10));
        wr(`ADC_CTL1_ADDR, 16'h8000);
        span(1'b1, n);
        repeat (10) @(posedge core_clk_i);
        #1 chk(16'(sampling_o), 16'h0000);
        wr(`ADC_CTL1_ADDR, 16'h0000);
        wr(`ADC_CTL3_ADDR, 16'h0300);
        wr(`ADC_CTL1_ADDR, 16'h8074);
        repeat (2)
        begin
            wait_sampling();
            span(1'b0, n);
            chk(16'(n), 16'h0003);
            span(1'b1, n);
            chk(16'(n), 16'h000C);
        end
        // RC clock paces the same free-running sequence
        wr(`ADC_CTL1_ADDR, 16'h0000);
        wr(`ADC_CTL3_ADDR, 16'h8300);
        wr(`ADC_CTL1_ADDR, 16'h8074);
        wait_sampling();
        span(1'b0, n);
        span(1'b1, n);
        chk(16'(n), 16'(`CONV_PERIODS * RC_PERIOD));
        analog_code_i <= 12'h0F0;
        while (converting_o !== 1'b1) @(posedge core_clk_i);
        repeat (8) @(posedge core_clk_i);
        wr(`ADC_CTL1_ADDR, 16'h0000);
        #1 chk(16'(converting_o), 16'h0000);
        rd(`ADC_RESULT_ADDR, 16'h05A2);
        rd(`ADC_CTL1_ADDR, 16'h0001);
        end_of_test();
    end
endmodule // adc_sample_convert_sequencer_tb
bind adc_sample_convert_sequencer adc_seq_asserts #(.CHANNELS(CHANNELS)) u_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .rc_osc_i(rc_osc_i),
    .analog_code_i(analog_code_i), .sampling_o(sampling_o), .converting_o(converting_o),
    .channel_o(channel_o));
`default_nettype wire
